/* logic/flash_ctrl_unit_pkg.sv */
// Package for the flash access controller: register map, commands, sizes, timing and types.
`default_nettype none
package flash_ctrl_unit_pkg;
  // Clock and slow debounce clock.
  localparam int CLK_HZ          = 40_000_000;
  localparam int SLOW_HZ         = 32_000;
  localparam int SLOW_DIV        = CLK_HZ / SLOW_HZ;
  // Erase pin qualification times, in ms, and their slow-tick counts.
  localparam int EP_IGNORE_MS    = 100;
  localparam int EP_ERASE_MS     = 220;
  localparam int EP_IGNORE_TICKS = EP_IGNORE_MS * SLOW_HZ / 1000;
  localparam int EP_ERASE_TICKS  = EP_ERASE_MS * SLOW_HZ / 1000;
  // Array organisation.
  localparam int PAGE_BYTES      = 256;
  localparam int PAGE_COUNT      = 1024;
  localparam int REGION_PAGES    = 64;
  localparam int LOCK_BITS       = 16;
  localparam int WBUF_BYTES      = 128;
  localparam int WBUF_WORDS      = WBUF_BYTES / 4;
  localparam int FUSE_BITS       = 3;
  localparam int RD_BITS         = 128;
  // Register byte addresses.
  localparam logic [11:0] A_CTRL = 12'h000;
  localparam logic [11:0] A_CMD  = 12'h004;
  localparam logic [11:0] A_STAT = 12'h008;
  localparam logic [11:0] A_RES  = 12'h00C;
  localparam logic [11:0] A_LOCK = 12'h010;
  localparam logic [11:0] A_FUSE = 12'h014;
  localparam logic [11:0] A_CAL  = 12'h018;
  localparam logic [11:0] A_UID  = 12'h020;
  localparam logic [11:0] A_WBUF = 12'h100;
  // Status bit positions.
  localparam int S_RDY   = 0;
  localparam int S_ERR   = 1;
  localparam int S_LOCK  = 2;
  localparam int S_FAST  = 3;
  localparam int S_SEC   = 4;
  localparam int S_SHORT = 5;
  // Control reset values.
  localparam logic [3:0] WS_RST     = 4'h0;
  localparam logic       NARROW_RST = 1'b0;
  // Command opcodes, bits [7:0] of the command word; argument in [17:8].
  localparam logic [7:0] OP_PROG = 8'h01;
  localparam logic [7:0] OP_ERPG = 8'h02;
  localparam logic [7:0] OP_EALL = 8'h03;
  localparam logic [7:0] OP_SETL = 8'h04;
  localparam logic [7:0] OP_CLRL = 8'h05;
  localparam logic [7:0] OP_SETF = 8'h06;
  localparam logic [7:0] OP_CLRF = 8'h07;
  localparam logic [7:0] OP_DESC = 8'h08;
  // Address decode: ROM stays at this base; a 4 MB window is compared.
  localparam logic [31:0] ROM_BASE = 32'h0080_0000;
  localparam int          MAP_LO   = 22;

  typedef struct packed {
    logic       wr;
    logic       erase;
    logic       erase_all;
    logic [9:0] page;
    logic [4:0] widx;
    logic [31:0] wdata;
  } arr_cmd_s;

  typedef enum logic [3:0] {
    ST_IDLE = 4'b0001,
    ST_PROG = 4'b0010,
    ST_WAIT = 4'b0100,
    ST_PIN  = 4'b1000
  } cmd_st_e;
endpackage
`default_nettype wire

/* logic/flash_ctrl_unit.sv */
// Flash access controller: APB registers, commands, read path, locks and fuse bits.
`timescale 1ns/1ps
`default_nettype none
module flash_ctrl_unit
  import flash_ctrl_unit_pkg::*;
#(
  parameter logic [12:0] EP_IGNORE_TICKS_P = 13'(EP_IGNORE_TICKS),
  parameter logic [12:0] EP_ERASE_TICKS_P  = 13'(EP_ERASE_TICKS)
) (
  input  wire logic         mclk_i,
  input  wire logic         reset_i,
  input  wire logic         psel_i,
  input  wire logic         penable_i,
  input  wire logic         pwrite_i,
  input  wire logic [11:0]  paddr_i,
  input  wire logic [31:0]  pwdata_i,
  output logic      [31:0]  prdata_o,
  output logic              pready_o,
  output logic              pslverr_o,
  input  wire logic         rd_req_i,
  input  wire logic [17:0]  rd_addr_i,
  output logic      [31:0]  rd_data_o,
  output logic              rd_valid_o,
  output arr_cmd_s          arr_cmd_o,
  output logic              arr_rd_o,
  output logic      [13:0]  arr_line_o,
  output logic              arr_narrow_o,
  input  wire logic [127:0] arr_rdata_i,
  input  wire logic         arr_done_i,
  input  wire logic [15:0]  nvm_lock_i,
  input  wire logic [2:0]   nvm_fuse_i,
  output logic      [15:0]  nvm_lock_o,
  output logic      [2:0]   nvm_fuse_o,
  input  wire logic [31:0]  calib_i,
  input  wire logic [127:0] uid_i,
  input  wire logic         erase_pin_i,
  input  wire logic         test_select_pin_i,
  input  wire logic         prog_strap_a_i,
  input  wire logic         prog_strap_b_i,
  input  wire logic         dbg_req_i,
  input  wire logic         fp_cmd_valid_i,
  input  wire logic [31:0]  fp_cmd_i,
  output logic              fast_prog_mode_o,
  output logic              access_refused_o,
  output logic              lock_irq_o,
  output logic              boot_flash_at_zero_o,
  input  wire logic [31:0]  map_addr_i,
  output logic              map_rom_o,
  output logic              map_flash_o
);
  logic [3:0]  sync1_reg, sync2_reg;
  logic [3:0]  ws_reg;
  logic        narrow_reg, ld_done_reg, cmd_err_reg, ep_short_reg, ep_go_reg;
  logic [15:0] lock_reg;
  logic [2:0]  fuse_reg;
  logic [31:0] result_reg;
  logic [31:0] wbuf [WBUF_WORDS];
  cmd_st_e     st_reg;
  logic [10:0] div_reg;
  logic        tick_reg;
  logic [12:0] ep_cnt_reg;
  logic        rd_act_reg;
  logic [3:0]  rd_cnt_reg;
  logic [4:0]  act_len;

  // Two-flop pin synchronisers; reset assumes idle straps so no false fast mode follows.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      sync1_reg <= 4'h7;
      sync2_reg <= 4'h7;
    end else begin
      sync1_reg <= {erase_pin_i, test_select_pin_i, prog_strap_a_i, prog_strap_b_i};
      sync2_reg <= sync1_reg;
    end
  end

  // APB decode; a write commits only at the edge where pready is seen high.
  wire        apb_wr   = psel_i & penable_i & pready_o & pwrite_i;
  wire        wbuf_hit = paddr_i[11:7] == A_WBUF[11:7];
  wire        stat_wr  = apb_wr & (paddr_i == A_STAT);
  wire        apb_cmd  = apb_wr & (paddr_i == A_CMD);
  // The fast port is shut out entirely while the part is secured.
  wire        fp_ok    = fp_cmd_valid_i & fast_prog_mode_o & ~fuse_reg[0];
  wire        cmd_go   = apb_cmd | fp_ok;
  wire [31:0] cmd_w    = apb_cmd ? pwdata_i : fp_cmd_i;
  wire [7:0]  op       = cmd_w[7:0];
  wire [9:0]  pg       = cmd_w[17:8];
  wire [1:0]  fidx     = cmd_w[9:8];
  wire        pg_lock  = lock_reg[pg[9:6]];
  wire        idle     = (st_reg == ST_IDLE) & ~ep_go_reg & ld_done_reg;
  wire        pin_fin  = (st_reg == ST_PIN) & arr_done_i;
  logic       ev_lock, ev_bad, go;
  logic [31:0] rdata_next;
  logic        rd_hit;

  // Command screening: busy, locked target and illegal fuse operations.
  always_comb begin
    ev_lock = 1'b0;
    ev_bad  = 1'b0;
    go      = 1'b0;
    if (cmd_go && !idle) begin
      ev_bad = 1'b1;
    end else if (cmd_go) begin
      case (op)
        OP_PROG, OP_ERPG: begin
          ev_lock = pg_lock;
          go      = ~pg_lock;
        end
        OP_EALL: begin
          ev_lock = |lock_reg;
          go      = ~|lock_reg;
        end
        OP_SETL, OP_CLRL, OP_DESC: go = 1'b1;
        OP_SETF: begin
          go     = 32'(fidx) < FUSE_BITS;
          ev_bad = ~go;
        end
        // Fuse 0 cannot be cleared by command.
        OP_CLRF: begin
          go     = (fidx != 2'h0) && (32'(fidx) < FUSE_BITS);
          ev_bad = ~go;
        end
        default: ev_bad = 1'b1;
      endcase
    end
  end

  // Register read mux; calibration and identifier have no write path at all.
  always_comb begin
    rdata_next = 32'h0000_0000;
    rd_hit     = 1'b1;
    if (wbuf_hit) begin
      rdata_next = wbuf[paddr_i[6:2]];
    end else if (paddr_i[11:4] == A_UID[11:4]) begin
      rdata_next = uid_i[{paddr_i[3:2], 5'h00} +: 32];
    end else begin
      case (paddr_i)
        A_CTRL: rdata_next = {27'h0, narrow_reg, ws_reg};
        A_CMD:  rdata_next = 32'h0000_0000;
        A_STAT: begin
          rdata_next[S_RDY]   = st_reg == ST_IDLE;
          rdata_next[S_ERR]   = cmd_err_reg;
          rdata_next[S_LOCK]  = lock_irq_o;
          rdata_next[S_FAST]  = fast_prog_mode_o;
          rdata_next[S_SEC]   = fuse_reg[0];
          rdata_next[S_SHORT] = ep_short_reg;
        end
        A_RES:  rdata_next = result_reg;
        A_LOCK: rdata_next = {16'h0, lock_reg};
        A_FUSE: rdata_next = {29'h0, fuse_reg};
        A_CAL:  rdata_next = calib_i;
        default: rd_hit = 1'b0;
      endcase
    end
  end

  // APB answer: one wait state, so data and pready leave flops together.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      pready_o  <= 1'b0;
      prdata_o  <= 32'h0000_0000;
      pslverr_o <= 1'b0;
    end else begin
      pready_o  <= psel_i & penable_i & ~pready_o;
      pslverr_o <= psel_i & penable_i & ~pready_o & ~rd_hit;
      if (psel_i && penable_i && !pready_o) begin
        prdata_o <= pwrite_i ? 32'h0000_0000 : rdata_next;
      end
    end
  end

  // Control register: wait states and the 64-bit narrowing option.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ws_reg     <= WS_RST;
      narrow_reg <= NARROW_RST;
    end else if (apb_wr && paddr_i == A_CTRL) begin
      ws_reg     <= pwdata_i[3:0];
      narrow_reg <= pwdata_i[4];
    end
  end

  // Write buffer; it returns to all ones once committed, like erased cells.
  always_ff @(posedge mclk_i) begin
    if (reset_i || (st_reg == ST_PROG && arr_cmd_o.widx == 5'(WBUF_WORDS - 1))) begin
      for (int i = 0; i < WBUF_WORDS; i++) begin
        wbuf[i] <= 32'hFFFF_FFFF;
      end
    end else if (apb_wr && wbuf_hit) begin
      wbuf[paddr_i[6:2]] <= pwdata_i;
    end
  end

  // Command sequencer towards the array; pin erase takes priority when idle.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      st_reg     <= ST_IDLE;
      arr_cmd_o  <= '0;
      result_reg <= 32'h0000_0000;
    end else begin
      arr_cmd_o.erase     <= 1'b0;
      arr_cmd_o.erase_all <= 1'b0;
      case (st_reg)
        ST_IDLE: begin
          if (ep_go_reg && ld_done_reg) begin
            arr_cmd_o.erase_all <= 1'b1;
            st_reg              <= ST_PIN;
          end else if (go) begin
            case (op)
              OP_PROG: begin
                arr_cmd_o.wr    <= 1'b1;
                arr_cmd_o.page  <= pg;
                arr_cmd_o.widx  <= 5'h00;
                arr_cmd_o.wdata <= wbuf[0];
                st_reg          <= ST_PROG;
              end
              OP_ERPG: begin
                arr_cmd_o.erase <= 1'b1;
                arr_cmd_o.page  <= pg;
                st_reg          <= ST_WAIT;
              end
              OP_EALL: begin
                arr_cmd_o.erase_all <= 1'b1;
                st_reg              <= ST_WAIT;
              end
              OP_DESC: begin
                case (pg[2:0])
                  3'h0: result_reg <= 32'(PAGE_BYTES);
                  3'h1: result_reg <= 32'(PAGE_COUNT);
                  3'h2: result_reg <= 32'(LOCK_BITS);
                  3'h3: result_reg <= 32'(REGION_PAGES);
                  3'h4: result_reg <= 32'(WBUF_BYTES);
                  3'h5: result_reg <= 32'(FUSE_BITS);
                  default: result_reg <= 32'h0000_0000;
                endcase
              end
              default: ;
            endcase
          end
        end
        ST_PROG: begin
          if (arr_cmd_o.widx == 5'(WBUF_WORDS - 1)) begin
            arr_cmd_o.wr <= 1'b0;
            st_reg       <= ST_WAIT;
          end else begin
            arr_cmd_o.widx  <= arr_cmd_o.widx + 5'h01;
            arr_cmd_o.wdata <= wbuf[arr_cmd_o.widx + 5'h01];
          end
        end
        ST_WAIT: if (arr_done_i) st_reg <= ST_IDLE;
        ST_PIN:  if (arr_done_i) st_reg <= ST_IDLE;
        default: st_reg <= ST_IDLE;
      endcase
    end
  end

  // Lock and fuse bits: loaded from the array's store after reset, written back through outputs.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      lock_reg    <= 16'h0000;
      fuse_reg    <= 3'h0;
      ld_done_reg <= 1'b0;
    end else if (!ld_done_reg) begin
      lock_reg    <= nvm_lock_i;
      fuse_reg    <= nvm_fuse_i;
      ld_done_reg <= 1'b1;
    end else if (pin_fin) begin
      lock_reg    <= 16'h0000;
      fuse_reg[0] <= 1'b0;
      fuse_reg[1] <= 1'b0;
    end else if (go) begin
      case (op)
        OP_SETL: lock_reg[pg[9:6]] <= 1'b1;
        OP_CLRL: lock_reg[pg[9:6]] <= 1'b0;
        OP_SETF: fuse_reg[fidx] <= 1'b1;
        OP_CLRF: fuse_reg[fidx] <= 1'b0;
        default: ;
      endcase
    end
  end
  assign nvm_lock_o = lock_reg;
  assign nvm_fuse_o = fuse_reg;

  // Sticky error flags; write one to clear, and a new event wins over the clear.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      cmd_err_reg <= 1'b0;
      lock_irq_o  <= 1'b0;
    end else begin
      cmd_err_reg <= ev_bad | (cmd_err_reg & ~(stat_wr & pwdata_i[S_ERR]));
      lock_irq_o  <= ev_lock | (lock_irq_o & ~(stat_wr & pwdata_i[S_LOCK]));
    end
  end

  // Slow clock enable from the system clock.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      div_reg  <= 11'h000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= div_reg == 11'(SLOW_DIV - 1);
      div_reg  <= (div_reg == 11'(SLOW_DIV - 1)) ? 11'h000 : div_reg + 11'h001;
    end
  end

  // Erase pin debounce; a pulse fires once, however long the pin stays high.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      ep_cnt_reg   <= 13'h0000;
      ep_go_reg    <= 1'b0;
      ep_short_reg <= 1'b0;
    end else begin
      if (tick_reg && sync2_reg[3]) begin
        if (ep_cnt_reg < EP_ERASE_TICKS_P) ep_cnt_reg <= ep_cnt_reg + 13'h0001;
      end else if (tick_reg) begin
        ep_cnt_reg <= 13'h0000;
      end
      if (tick_reg && sync2_reg[3] && ep_cnt_reg == EP_ERASE_TICKS_P - 13'h0001) begin
        ep_go_reg <= 1'b1;
      end else if (st_reg == ST_IDLE && ld_done_reg) begin
        ep_go_reg <= 1'b0;
      end
      // A release between the two limits is flagged but never erases.
      if (tick_reg && !sync2_reg[3] && ep_cnt_reg >= EP_IGNORE_TICKS_P
          && ep_cnt_reg < EP_ERASE_TICKS_P) begin
        ep_short_reg <= 1'b1;
      end else if (stat_wr && pwdata_i[S_SHORT]) begin
        ep_short_reg <= 1'b0;
      end
    end
  end

  // Read path: one line fetch, then the programmed wait states, then the word.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      rd_act_reg   <= 1'b0;
      rd_cnt_reg   <= 4'h0;
      arr_rd_o     <= 1'b0;
      arr_line_o   <= 14'h0000;
      arr_narrow_o <= NARROW_RST;
      rd_valid_o   <= 1'b0;
      rd_data_o    <= 32'h0000_0000;
    end else begin
      rd_valid_o   <= 1'b0;
      arr_narrow_o <= narrow_reg;
      if (!rd_act_reg && rd_req_i && !rd_valid_o && st_reg == ST_IDLE) begin
        rd_act_reg <= 1'b1;
        arr_rd_o   <= 1'b1;
        arr_line_o <= rd_addr_i[17:4];
        rd_cnt_reg <= ws_reg;
      end else if (rd_act_reg) begin
        if (rd_cnt_reg == 4'h0) begin
          rd_act_reg <= 1'b0;
          arr_rd_o   <= 1'b0;
          rd_valid_o <= 1'b1;
          rd_data_o  <= arr_rdata_i[{rd_addr_i[3:2], 5'h00} +: 32];
        end else begin
          rd_cnt_reg <= rd_cnt_reg - 4'h1;
        end
      end
    end
  end

  // Mode, security and address map outputs.
  always_ff @(posedge mclk_i) begin
    if (reset_i) begin
      fast_prog_mode_o     <= 1'b0;
      access_refused_o     <= 1'b0;
      boot_flash_at_zero_o <= 1'b0;
      map_rom_o            <= 1'b0;
      map_flash_o          <= 1'b0;
    end else begin
      fast_prog_mode_o     <= sync2_reg[2:0] == 3'b000;
      access_refused_o     <= (fuse_reg[0] | ~ld_done_reg) & (dbg_req_i | fast_prog_mode_o);
      boot_flash_at_zero_o <= fuse_reg[1];
      map_rom_o            <= (map_addr_i[31:MAP_LO] == ROM_BASE[31:MAP_LO])
                              | (map_addr_i[31:MAP_LO] == '0 & ~fuse_reg[1]);
      map_flash_o          <= (map_addr_i[31:MAP_LO] == '0) & fuse_reg[1];
    end
  end

  // Helper: length of the current read's wait phase.
  always_ff @(posedge mclk_i) begin
    if (reset_i || !rd_act_reg) act_len <= 5'h00;
    else act_len <= act_len + 5'h01;
  end

  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);
  sequence s_prog_go;
    go && op == OP_PROG;
  endsequence
  sequence s_burst;
    arr_cmd_o.wr ##31 (arr_cmd_o.wr && arr_cmd_o.widx == 5'h1F) ##1 !arr_cmd_o.wr;
  endsequence

  a_lock_abort: assert property (cmd_go && idle && (op == OP_PROG || op == OP_ERPG) && pg_lock
    |=> lock_irq_o && !arr_cmd_o.wr && !arr_cmd_o.erase) else $error("locked command not aborted");
  a_prog_burst: assert property (s_prog_go |=> s_burst) else $error("program burst wrong");
  a_busy_refuse: assert property (cmd_go && st_reg != ST_IDLE |=> cmd_err_reg)
    else $error("busy command not refused");
  a_wait_states: assert property ($rose(rd_valid_o) && $stable(ws_reg)
    |-> act_len == 5'(ws_reg) + 5'h01) else $error("wait state count wrong");
  a_secure_dbg: assert property (fuse_reg[0] && dbg_req_i |=> access_refused_o)
    else $error("secured debug access not refused");
  a_fast_entry: assert property (sync2_reg[2:0] == 3'b000 |=> fast_prog_mode_o)
    else $error("fast mode not entered");
  a_rom_fixed: assert property (map_addr_i[31:MAP_LO] == ROM_BASE[31:MAP_LO] |=> map_rom_o)
    else $error("rom not decoded");
  a_pin_clear: assert property (pin_fin |=> lock_reg == 16'h0000 && !fuse_reg[0])
    else $error("pin erase left locks");
  a_boot_rom: assert property (pin_fin |=> ##1 !boot_flash_at_zero_o)
    else $error("boot not back to rom");
  a_fuse0_pin: assert property (ld_done_reg && $fell(fuse_reg[0]) |-> $past(pin_fin))
    else $error("security bit cleared without pin erase");
  a_ep_qualify: assert property ($rose(ep_go_reg) |-> ep_cnt_reg == EP_ERASE_TICKS_P)
    else $error("erase pin fired early");
endmodule // flash_ctrl_unit
`default_nettype wire

/* verif/flash_macro_model.sv */
// Behavioural flash array macro facing the controller's array port.
`timescale 1ns/1ps
`default_nettype none
module flash_macro_model
  import flash_ctrl_unit_pkg::*;
(
  input  wire logic         mclk_i,
  input  wire arr_cmd_s     cmd_i,
  input  wire logic         rd_i,
  input  wire logic [13:0]  line_i,
  input  wire logic [15:0]  lock_i,
  input  wire logic [2:0]   fuse_i,
  output logic      [127:0] rdata_o,
  output logic              done_o,
  output logic      [15:0]  lock_o,
  output logic      [2:0]   fuse_o
);
  logic [7:0] cnt = 8'h00;

  // Each word carries its lane and line; outside a fetch the lanes show the inverse.
  always_comb begin
    for (int w = 0; w < 4; w++) begin
      rdata_o[32*w +: 32] = {14'h0, 2'(w), 2'h0, line_i} ^ {32{~rd_i}};
    end
  end

  // Busy time depends on the page: odd pages complete quickly, even pages slowly.
  always_ff @(posedge mclk_i) begin
    done_o <= 1'b0;
    lock_o <= lock_i;
    fuse_o <= fuse_i;
    if (cmd_i.erase || cmd_i.erase_all || (cmd_i.wr && cmd_i.widx == 5'h1F)) begin
      cnt <= cmd_i.page[0] ? 8'h03 : 8'h28;
    end else if (cnt == 8'h01) begin
      done_o <= 1'b1;
      cnt    <= 8'h00;
    end else if (cnt != 8'h00) begin
      cnt <= cnt - 8'h01;
    end
  end
endmodule // flash_macro_model
`default_nettype wire

/* verif/tb_top.sv */
// Self-checking bench for the flash controller with a behavioural array macro.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, x) begin cmp_count++; if ((g) !== (x)) begin miscompares++; \
  $display("BAD %0t got %0h exp %0h", $time, g, x); end end
module tb_top;
  import flash_ctrl_unit_pkg::*;
  logic         mclk, reset, psel, penable, pwrite, pready, pslverr, rd_req, rd_valid, e;
  logic         arr_rd, arr_narrow, arr_done, erase_pin, tst, sa, sb, dbg, fpv, nar;
  logic         fast, refused, irq, boot0, m_rom, m_flash;
  logic [11:0]  paddr;
  logic [31:0]  pwdata, prdata, rd_data, calib, fpc, map_addr, q, seed, wd_last, wd_exp;
  logic [17:0]  rd_addr, ra;
  logic [13:0]  arr_line;
  logic [127:0] arr_rdata, uid;
  logic [15:0]  lock_o, lock_i;
  logic [2:0]   fuse_o, fuse_i;
  logic [9:0]   pg;
  logic [3:0]   ws;
  arr_cmd_s     arr_cmd;
  int           miscompares, cmp_count, wr_cnt, n;
  int           dsc[6] = '{PAGE_BYTES, PAGE_COUNT, LOCK_BITS, REGION_PAGES, WBUF_BYTES, FUSE_BITS};

  flash_ctrl_unit #(.EP_IGNORE_TICKS_P(13'h4), .EP_ERASE_TICKS_P(13'h8)) i_flash_ctrl_unit (
    .mclk_i(mclk), .reset_i(reset), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
    .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .rd_req_i(rd_req), .rd_addr_i(rd_addr), .rd_data_o(rd_data),
    .rd_valid_o(rd_valid), .arr_cmd_o(arr_cmd), .arr_rd_o(arr_rd), .arr_line_o(arr_line),
    .arr_narrow_o(arr_narrow), .arr_rdata_i(arr_rdata), .arr_done_i(arr_done),
    .nvm_lock_i(lock_i), .nvm_fuse_i(fuse_i), .nvm_lock_o(lock_o), .nvm_fuse_o(fuse_o),
    .calib_i(calib), .uid_i(uid), .erase_pin_i(erase_pin), .test_select_pin_i(tst),
    .prog_strap_a_i(sa), .prog_strap_b_i(sb), .dbg_req_i(dbg), .fp_cmd_valid_i(fpv),
    .fp_cmd_i(fpc), .fast_prog_mode_o(fast), .access_refused_o(refused), .lock_irq_o(irq),
    .boot_flash_at_zero_o(boot0), .map_addr_i(map_addr), .map_rom_o(m_rom),
    .map_flash_o(m_flash));
  flash_macro_model i_flash_macro_model (.mclk_i(mclk), .cmd_i(arr_cmd), .rd_i(arr_rd),
    .line_i(arr_line), .lock_i(lock_o), .fuse_i(fuse_o), .rdata_o(arr_rdata),
    .done_o(arr_done), .lock_o(lock_i), .fuse_o(fuse_i));

  // Free-running system clock.
  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Program beats into the chosen page are counted.
  // The last beat's data is kept to check that buffer word 31 lands on index 31.
  always @(posedge mclk) begin
    if (arr_cmd.wr === 1'b1 && arr_cmd.page === pg) begin
      wr_cnt++;
      wd_last = arr_cmd.wdata;
    end
  end

  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  // Word the macro model presents for a byte address.
  function automatic logic [31:0] line_word(logic [17:0] a);
    return {14'h0, a[3:2], 2'h0, a[17:4]};
  endfunction

  task automatic summarize();
    $display("Comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic tmo(input int k);
    if (k >= 200) begin
      miscompares++;
      summarize();
    end
  endtask
  // One APB transfer; the request is held until pready is seen at an edge.
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 200);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
    tmo(n);
  endtask
  task automatic ready_wait();
    int k;
    k = 0;
    do begin
      apb(1'b0, A_STAT, 32'h0);
      k++;
    end while (q[S_RDY] !== 1'b1 && k < 200);
    tmo(k);
  endtask
  task automatic cmd(input logic [7:0] op, input logic [9:0] arg);
    apb(1'b1, A_CMD, {14'h0, arg, op});
    ready_wait();
  endtask

  initial begin
    seed = 32'h28;
    {psel, penable, pwrite, rd_req, dbg, fpv, erase_pin} = '0;
    {paddr, pwdata, rd_addr, fpc, map_addr} = '0;
    {tst, sa, sb} = 3'h7;
    calib = rnd();
    uid = {rnd(), rnd(), rnd(), rnd()};
    reset = 1'b1;
    repeat (3) @(posedge mclk);
    reset <= 1'b0;
    repeat (2) @(posedge mclk);
    apb(1'b0, A_CTRL, 32'h0);
    `CHK(q[4:0], {NARROW_RST, WS_RST})
    apb(1'b0, 12'h0FC, 32'h0);
    `CHK(e, 1'b1)
    apb(1'b1, A_CAL, rnd());
    apb(1'b0, A_CAL, 32'h0);
    `CHK(q, calib)
    apb(1'b0, A_UID + 12'h8, 32'h0);
    `CHK(q, uid[95:64])
    for (int i = 0; i < 6; i++) begin
      cmd(OP_DESC, 10'(i));
      apb(1'b0, A_RES, 32'h0);
      `CHK(q, 32'(dsc[i]))
    end
    // Reads with extreme and random wait states and both path widths.
    for (int i = 0; i < 8; i++) begin
      q = rnd();
      ws = (i == 0) ? 4'h0 : (i == 1) ? 4'hF : q[3:0];
      ra = q[25:8];
      nar = q[4];
      apb(1'b1, A_CTRL, {27'h0, nar, ws});
      rd_req  <= 1'b1;
      rd_addr <= ra;
      n = 0;
      do begin
        @(posedge mclk);
        n++;
      end while (rd_valid !== 1'b1 && n < 200);
      tmo(n);
      `CHK(n, ws + 3)
      `CHK(rd_data, line_word(ra))
      `CHK(arr_narrow, nar)
      rd_req  <= 1'b0;
      rd_addr <= ~ra;
      @(posedge mclk);
    end
    q = rnd();
    pg = q[9:0];
    cmd(OP_SETL, pg);
    apb(1'b0, A_LOCK, 32'h0);
    `CHK(q[15:0], 16'h1 << pg[9:6])
    wr_cnt = 0;
    cmd(OP_PROG, pg);
    `CHK(irq, 1'b1)
    `CHK(wr_cnt, 0)
    apb(1'b1, A_STAT, 32'h4);
    cmd(OP_CLRL, pg);
    apb(1'b0, A_LOCK, 32'h0);
    `CHK(q[15:0], 16'h0)
    wd_exp = rnd();
    apb(1'b1, A_WBUF + 12'h7C, wd_exp);
    apb(1'b1, A_CMD, {14'h0, pg, OP_PROG});
    apb(1'b1, A_CMD, {14'h0, pg, OP_SETF});
    apb(1'b0, A_STAT, 32'h0);
    `CHK(q[S_ERR:S_RDY], 2'b10)
    ready_wait();
    `CHK(wr_cnt, WBUF_WORDS)
    `CHK(wd_last, wd_exp)
    apb(1'b0, A_WBUF + 12'h7C, 32'h0);
    `CHK(q, 32'hFFFFFFFF)
    cmd(OP_SETL, pg);
    erase_pin <= 1'b1;
    repeat (5 * SLOW_DIV) @(posedge mclk);
    erase_pin <= 1'b0;
    // The release is only seen at the next slow tick, up to one divider period later.
    repeat (SLOW_DIV + 10) @(posedge mclk);
    apb(1'b0, A_STAT, 32'h0);
    `CHK(q[S_SHORT], 1'b1)
    apb(1'b0, A_LOCK, 32'h0);
    `CHK(q[15:0], 16'h1 << pg[9:6])
    for (int f = 0; f < 3; f++) begin
      cmd(OP_SETF, 10'(f));
      apb(1'b0, A_FUSE, 32'h0);
      `CHK(q[f], 1'b1)
    end
    `CHK(boot0, 1'b1)
    map_addr <= 32'h0;
    repeat (2) @(posedge mclk);
    `CHK(m_flash, 1'b1)
    map_addr <= ROM_BASE;
    dbg      <= 1'b1;
    repeat (2) @(posedge mclk);
    `CHK(m_rom, 1'b1)
    `CHK(refused, 1'b1)
    cmd(OP_CLRF, 10'h0);
    cmd(OP_CLRF, 10'h2);
    apb(1'b0, A_FUSE, 32'h0);
    `CHK(q[2:0], 3'h3)
    // A long erase pin hold, past the qualification time.
    erase_pin <= 1'b1;
    repeat (10 * SLOW_DIV) @(posedge mclk);
    erase_pin <= 1'b0;
    ready_wait();
    apb(1'b0, A_LOCK, 32'h0);
    `CHK(q[15:0], 16'h0)
    apb(1'b0, A_FUSE, 32'h0);
    `CHK(q[1:0], 2'h0)
    `CHK(refused, 1'b0)
    `CHK(boot0, 1'b0)
    map_addr <= 32'h0;
    repeat (2) @(posedge mclk);
    `CHK(m_rom, 1'b1)
    `CHK(m_flash, 1'b0)
    {tst, sa, sb} <= 3'h0;
    repeat (4) @(posedge mclk);
    `CHK(fast, 1'b1)
    fpc <= {14'h0, pg, OP_SETL};
    fpv <= 1'b1;
    @(posedge mclk);
    fpv <= 1'b0;
    ready_wait();
    apb(1'b0, A_LOCK, 32'h0);
    `CHK(q[15:0], 16'h1 << pg[9:6])
    summarize();
  end
endmodule // tb_top
`default_nettype wire
